// ==== rtl/hmvf_top.v ====
`timescale 1ns/100ps
`include "hmvf_consts.vh"
module hmvf_top (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire soft_rst,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] rx_data,
  input wire rx_last,
  input wire rx_valid,
  output reg rx_ready,
  output reg [7:0] fab_data,
  output reg fab_last,
  output reg fab_valid,
  input wire fab_ready,
  output reg fab_too_long,
  output reg fab_tag1,
  output reg fab_tag2,
  output reg [255:0] wake_filter_words
);
  // Registers
  reg [15:0] first_tag_value_q;
  reg [15:0] second_tag_value_q;
  reg [2:0] wuff_ptr_q;
  reg chk_en_q;
  reg [15:0] long_cnt_q;
  reg [15:0] frame_cnt_q;
  // AXI write state
  reg aw_held_q;
  reg w_held_q;
  reg [3:0] aw_idx_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  // Byte addresses; the two low bits are ignored, words only
  wire [3:0] aw_idx = s_axi_awaddr[`HMVF_IDX_MSB:`HMVF_IDX_LSB];
  wire [3:0] ar_idx = s_axi_araddr[`HMVF_IDX_MSB:`HMVF_IDX_LSB];
  wire [3:0] wr_idx = s_axi_awvalid && s_axi_awready ? aw_idx
    : aw_idx_q;
  wire [31:0] wr_dat = s_axi_wvalid && s_axi_wready ? s_axi_wdata
    : w_data_q;
  wire [3:0] wr_stb = s_axi_wvalid && s_axi_wready ? s_axi_wstrb
    : w_strb_q;
  wire aw_have = aw_held_q || (s_axi_awvalid && s_axi_awready);
  wire w_have = w_held_q || (s_axi_wvalid && s_axi_wready);
  wire wr_go = aw_have && w_have && !s_axi_bvalid;
  wire wr_map = (wr_idx == `HMVF_IDX_TAG1) || (wr_idx == `HMVF_IDX_TAG2)
    || (wr_idx == `HMVF_IDX_WUFF) || (wr_idx == `HMVF_IDX_CTRL);
  wire ptr_rst = !aresetn || soft_rst;
  // Rx framing and the FIFO
  wire fifo_in_ready;
  wire [8:0] fifo_out;
  wire fifo_out_valid;
  reg fifo_pop;
  reg [10:0] byte_cnt_q;
  reg [7:0] type_hi_q;
  reg tag1_q;
  reg tag2_q;
  reg [10:0] max_len_q;
  wire rx_take = rx_valid && rx_ready;
  wire [15:0] type_word = {type_hi_q, rx_data};
  wire hit1 = (type_word == first_tag_value_q);
  wire hit2 = (type_word == second_tag_value_q);
  // One writer per filter slot; the pointer picks which one fires
  genvar gi;
  generate
    for (gi = 0; gi < `HMVF_WUFF_N; gi = gi + 1)
    begin : g_wf
      always @(posedge aclk)
      begin
        if (!aresetn)
          wake_filter_words[gi*32 +: 32] <= 32'h00000000;
        else if (ce && wr_go && wr_idx == `HMVF_IDX_WUFF
                 && wuff_ptr_q == gi)
          wake_filter_words[gi*32 +: 32] <= wr_dat;
      end
    end
  endgenerate
  always @(posedge aclk)
  begin
    if (ptr_rst)
      wuff_ptr_q <= 3'h0;
    else if (ce && wr_go && wr_idx == `HMVF_IDX_WUFF)
      wuff_ptr_q <= (wuff_ptr_q == `HMVF_WUFF_LAST) ? 3'h0
        : wuff_ptr_q + 3'h1;
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HMVF_RESP_OK;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      first_tag_value_q <= `HMVF_TAG_RST;
      second_tag_value_q <= `HMVF_TAG_RST;
      chk_en_q <= 1'b1;
    end
    else if (ce)
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `HMVF_RESP_OK : `HMVF_RESP_DEC;
        if (wr_idx == `HMVF_IDX_TAG1)
        begin
          if (wr_stb[0])
            first_tag_value_q[7:0] <= wr_dat[7:0];
          if (wr_stb[1])
            first_tag_value_q[15:8] <= wr_dat[15:8];
        end
        if (wr_idx == `HMVF_IDX_TAG2)
        begin
          if (wr_stb[0])
            second_tag_value_q[7:0] <= wr_dat[7:0];
          if (wr_stb[1])
            second_tag_value_q[15:8] <= wr_dat[15:8];
        end
        if (wr_idx == `HMVF_IDX_CTRL && wr_stb[0])
          chk_en_q <= wr_dat[0];
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_held_q <= 1'b1;
          aw_idx_q <= aw_idx;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        s_axi_awready <= !aw_have && !s_axi_bvalid && !s_axi_awready;
        s_axi_wready <= !w_have && !s_axi_bvalid && !s_axi_wready;
      end
    end
  end
  // Read channel: one-cycle accept, data in the next
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `HMVF_RESP_OK;
    end
    else if (ce)
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `HMVF_RESP_OK;
        case (ar_idx)
          `HMVF_IDX_TAG1: s_axi_rdata <= {16'h0000, first_tag_value_q};
          `HMVF_IDX_TAG2: s_axi_rdata <= {16'h0000, second_tag_value_q};
          `HMVF_IDX_WUFF: s_axi_rdata <= 32'h00000000;
          `HMVF_IDX_CTRL: s_axi_rdata <= {31'h0, chk_en_q};
          `HMVF_IDX_STAT: s_axi_rdata <= {frame_cnt_q, long_cnt_q};
          `HMVF_IDX_PTR: s_axi_rdata <= {29'h0, wuff_ptr_q};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HMVF_RESP_DEC;
          end
        endcase
      end
      else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
        s_axi_arready <= 1'b1;
    end
  end
  // Receive classification
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      byte_cnt_q <= 11'd0;
      type_hi_q <= 8'h00;
      tag1_q <= 1'b0;
      tag2_q <= 1'b0;
      max_len_q <= `HMVF_LEN_UNTAG;
      rx_ready <= 1'b0;
      long_cnt_q <= 16'h0000;
      frame_cnt_q <= 16'h0000;
    end
    else if (ce)
    begin
      // Registered ready lags the FIFO by a cycle, so it pauses after
      // each taken byte: half rate, but the FIFO can never overfill
      rx_ready <= fifo_in_ready && !rx_take;
      if (rx_take)
      begin
        if (byte_cnt_q == `HMVF_TYPE_HI)
          type_hi_q <= rx_data;
        if (byte_cnt_q == `HMVF_TYPE_LO)
        begin
          tag1_q <= hit1;
          tag2_q <= hit2 && !hit1;
          if (hit1)
            max_len_q <= `HMVF_LEN_TAG1;
          else if (hit2)
            max_len_q <= `HMVF_LEN_TAG2;
          else
            max_len_q <= `HMVF_LEN_UNTAG;
        end
        if (rx_last)
        begin
          byte_cnt_q <= 11'd0;
          // Short frames must not inherit the previous tag limit
          max_len_q <= `HMVF_LEN_UNTAG;
          frame_cnt_q <= frame_cnt_q + 16'h0001;
          if (chk_en_q && byte_cnt_q >= max_len_q)
            long_cnt_q <= long_cnt_q + 16'h0001;
        end
        else if (byte_cnt_q != 11'h7ff)
          byte_cnt_q <= byte_cnt_q + 11'd1;
      end
    end
  end
  // FIFO only sees bytes when ready was offered, so no byte is dropped
  hmvf_fifo #(
    .WIDTH(`HMVF_FIFO_W),
    .DEPTH(`HMVF_FIFO_D),
    .AW(`HMVF_FIFO_AW)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_data({rx_last, rx_data}),
    .in_valid(rx_take),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );
  always @*
  begin
    fifo_pop = !fab_valid || fab_ready;
  end
  // Status flags reflect the latest classified frame
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fab_data <= 8'h00;
      fab_last <= 1'b0;
      fab_valid <= 1'b0;
      fab_too_long <= 1'b0;
      fab_tag1 <= 1'b0;
      fab_tag2 <= 1'b0;
    end
    else if (ce)
    begin
      fab_tag1 <= tag1_q;
      fab_tag2 <= tag2_q;
      // Sticky until the next frame starts, as the last byte clears the count
      if (rx_take)
        fab_too_long <= chk_en_q
          && (byte_cnt_q >= max_len_q
          || (fab_too_long && byte_cnt_q != 11'd0));
      if (fifo_pop)
      begin
        fab_valid <= fifo_out_valid;
        fab_data <= fifo_out[7:0];
        fab_last <= fifo_out[8];
      end
    end
  end
endmodule

// ==== rtl/hmvf_consts.vh ====
// How it works
// - Match first tag on frame bytes 13-14
// - First-tag frame allows 1522 bytes maximum
// - Match second tag on same bytes
// - Second-tag frame allows 1538 bytes maximum
// - Tag fields low 16 bits, reset ffff
// - Equal tags: first wins, 1522 bytes
// - Filter words loaded through one indexed port
// - Any reset returns filter pointer to zero
// - Pointer wraps after eight words
// - Filter port is write-only, reads zero
`ifndef HMVF_CONSTS_VH
`define HMVF_CONSTS_VH
`define HMVF_IDX_TAG1 4'h9
`define HMVF_IDX_TAG2 4'ha
`define HMVF_IDX_WUFF 4'hb
`define HMVF_IDX_CTRL 4'hd
`define HMVF_IDX_STAT 4'he
`define HMVF_IDX_PTR 4'hf
`define HMVF_IDX_MSB 5
`define HMVF_IDX_LSB 2
`define HMVF_WUFF_N 8
`define HMVF_TAG_RST 16'hffff
`define HMVF_LEN_UNTAG 11'd1518
`define HMVF_LEN_TAG1 11'd1522
`define HMVF_LEN_TAG2 11'd1538
`define HMVF_TYPE_HI 11'd12
`define HMVF_TYPE_LO 11'd13
`define HMVF_WUFF_LAST 3'h7
`define HMVF_RESP_OK 2'b00
`define HMVF_RESP_DEC 2'b11
`define HMVF_FIFO_W 9
`define HMVF_FIFO_D 32
`define HMVF_FIFO_AW 5
`endif

// ==== rtl/hmvf_fifo.v ====
`timescale 1ns/100ps
module hmvf_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire empty = (wp_q == rp_q);
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire push = in_valid && !full;
  wire pop = !empty && (!out_valid || out_ready);
  assign in_ready = !full;
  always @(posedge aclk)
  begin
    if (ce && push)
      mem[wp_q[AW-1:0]] <= in_data;
  end
  // Registered read output acts as one extra slot
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
      begin
        rp_q <= rp_q + 1'b1;
        out_data <= mem[rp_q[AW-1:0]];
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule

// ==== testbench/hmvf_fab_sink.sv ====
`timescale 1ns/100ps
module hmvf_fab_sink (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] fab_data,
  input wire fab_last,
  input wire fab_valid,
  input wire slow,
  output logic fab_ready,
  output int frames
);
  logic [7:0] lf_q;
  // Pseudo-random stalls so the FIFO sees uneven drain
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lf_q <= 8'h5a;
      fab_ready <= 1'b0;
      frames <= 0;
    end
    else
    begin
      lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
      fab_ready <= slow ? lf_q[2:0] == 3'h0 : lf_q[1:0] != 2'h0;
      if (fab_valid && fab_ready && fab_last)
        frames <= frames + 1;
    end
  end
endmodule

// ==== testbench/hmvf_top_properties.sv ====
`timescale 1ns/100ps
module hmvf_checker (
  input wire aclk,
  input wire aresetn,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] fab_data,
  input wire fab_valid,
  input wire fab_ready,
  input wire fab_tag1,
  input wire fab_tag2
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar(logic [3:0] idx);
    s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] == idx;
  endsequence
  a_tag_exclusive: assert property (!(fab_tag1 && fab_tag2))
    else $error("both tag flags high");
  a_filter_read_zero: assert property (s_ar(4'hb) |=>
    s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == 2'b00)
    else $error("filter port read not zero");
  a_tag_upper_zero: assert property ((s_ar(4'h9) or s_ar(4'ha)) |=>
    s_axi_rvalid && s_axi_rdata[31:16] == 16'h0)
    else $error("tag upper bits not zero");
  a_ptr_upper_zero: assert property (s_ar(4'hf) |=>
    s_axi_rvalid && s_axi_rdata[31:3] == 29'h0)
    else $error("pointer wider than eight entries");
  a_unmapped_decerr: assert property (s_ar(4'h0) |=>
    s_axi_rvalid && s_axi_rresp == 2'b11)
    else $error("unmapped read not refused");
  a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid)
    else $error("read answered twice");
  a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid)
    else $error("write answered twice");
  a_fab_hold: assert property (fab_valid && !fab_ready |=>
    fab_valid && $stable(fab_data))
    else $error("fabric byte dropped while stalled");
endmodule
bind hmvf_top hmvf_checker u_hmvf_checker (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .fab_data(fab_data),
  .fab_valid(fab_valid),
  .fab_ready(fab_ready),
  .fab_tag1(fab_tag1),
  .fab_tag2(fab_tag2)
);

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic aclk = 0, aresetn = 0, ce = 1, soft_rst = 0, slow = 0;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, rx_last = 0, rx_valid = 0;
  logic [31:0] s_axi_wdata = 0, rdat, seed = 32'he6f7a39b, wf[8], d;
  logic [7:0] rx_data = 0;
  logic [1:0] rrsp, brsp;
  logic [15:0] t2, ty;
  logic [8:0] exp_q[$];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, rx_ready, fab_last, fab_valid, fab_ready;
  wire fab_too_long, fab_tag1, fab_tag2;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] fab_data;
  wire [255:0] wake_filter_words;
  int n_fail = 0, cmp_count = 0, cyc = 0, frames;
  hmvf_top u_hmvf_top (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .soft_rst(soft_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rx_data(rx_data),
    .rx_last(rx_last),
    .rx_valid(rx_valid),
    .rx_ready(rx_ready),
    .fab_data(fab_data),
    .fab_last(fab_last),
    .fab_valid(fab_valid),
    .fab_ready(fab_ready),
    .fab_too_long(fab_too_long),
    .fab_tag1(fab_tag1),
    .fab_tag2(fab_tag2),
    .wake_filter_words(wake_filter_words)
  );
  hmvf_fab_sink u_hmvf_fab_sink (
    .aclk(aclk),
    .aresetn(aresetn),
    .fab_data(fab_data),
    .fab_last(fab_last),
    .fab_valid(fab_valid),
    .slow(slow),
    .fab_ready(fab_ready),
    .frames(frames)
  );
  always #12.5 aclk = ~aclk;
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function int maxlen(input logic [15:0] ty, t1, t2);
    if (ty == t1)
      return 1522;
    if (ty == t2)
      return 1538;
    return 1518;
  endfunction
  task summarize();
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wready)
        s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    brsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task frame(input logic [15:0] ty, input int len);
    for (int k = 0; k < len; k++)
    begin
      rx_data <= k == 12 ? ty[15:8] : k == 13 ? ty[7:0] : 8'(xs());
      rx_last <= k == len - 1;
      rx_valid <= 1;
      do @(posedge aclk); while (!rx_ready);
      exp_q.push_back({rx_last, rx_data});
    end
    rx_valid <= 0;
    rx_last <= 0;
  endtask
  // Hang guard sized for the whole run, slow-drain frame included, plus margin
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_fail++;
      summarize();
    end
  end
  // Every byte taken on the receive side must come out unchanged
  always @(posedge aclk)
  begin
    if (aresetn && fab_valid && fab_ready)
      chk("fabric byte", {fab_last, fab_data}, exp_q.pop_front());
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(4'h9);
    chk("tag1 reset", rdat, 32'h0000ffff);
    rd(4'h0);
    chk("unmapped read", rrsp, 2'b11);
    wr(4'h1, 32'h1);
    chk("unmapped write", brsp, 2'b11);
    wr(4'h9, 32'hffff8100);
    wr(4'ha, 32'h88a8);
    rd(4'h9);
    chk("tag1 value", rdat, 32'h8100);
    for (int i = 0; i < 8; i++)
    begin
      t2 = i < 6 ? 16'h88a8 : 16'h8100;
      // Equal tags on purpose to see which one wins
      if (i == 6)
        wr(4'ha, {16'h0, t2});
      ty = i < 2 ? 16'h0800 : i < 4 ? 16'h8100 : t2;
      slow <= i == 1;
      frame(ty, maxlen(ty, 16'h8100, t2) + i % 2);
      while (frames != i + 1) @(posedge aclk);
      chk("tag1 flag", fab_tag1, ty == 16'h8100);
      chk("tag2 flag", fab_tag2, ty == t2 && ty != 16'h8100);
      chk("too long", fab_too_long, i % 2);
    end
    rd(4'he);
    chk("status", rdat, {16'd8, 16'd4});
    wr(4'hd, 32'h0);
    rd(4'hd);
    chk("ctrl", rdat, 32'h0);
    frame(16'h0800, 1519);
    while (frames != 9) @(posedge aclk);
    chk("too long off", fab_too_long, 0);
    rd(4'he);
    chk("status off", rdat, {16'd9, 16'd4});
    for (int i = 0; i < 9; i++)
    begin
      d = xs();
      wf[i % 8] = d;
      wr(4'hb, d);
    end
    rd(4'hb);
    chk("filter read", rdat, 32'h0);
    rd(4'hf);
    chk("pointer", rdat, 32'h1);
    for (int i = 0; i < 8; i++)
      chk("filter word", wake_filter_words[32*i+:32], wf[i]);
    soft_rst <= 1;
    @(posedge aclk);
    soft_rst <= 0;
    rd(4'hf);
    chk("pointer soft", rdat, 32'h0);
    d = xs();
    wr(4'hb, d);
    rd(4'hf);
    chk("word0 soft", wake_filter_words[31:0], d);
    aresetn <= 0;
    @(posedge aclk);
    aresetn <= 1;
    rd(4'hf);
    chk("pointer reset", rdat, 32'h0);
    summarize();
  end
endmodule
